// ### mad_defines.vh
`ifndef MAD_DEFINES_VH
`define MAD_DEFINES_VH
// Register byte offsets.
`define MAD_OFS_EC_WIDTH 8'h0e
`define MAD_OFS_COL_DELAY 8'h0f
`define MAD_OFS_BURST 8'h10
`define MAD_OFS_BANKS 8'h11
`define MAD_OFS_CAS_LAT 8'h12
`define MAD_OFS_CS_LAT 8'h13
`define MAD_OFS_WE_LAT 8'h14
`define MAD_OFS_MOD_FEAT 8'h15
`define MAD_OFS_DEV_FEAT 8'h16
`define MAD_OFS_CYCLE2 8'h17
// Control and status registers of this block.
`define MAD_OFS_CTRL 8'h00
`define MAD_OFS_STATUS 8'h01
`define MAD_OFS_CYC2_NS 8'h02
`define MAD_OFS_CYC2_TENTHS 8'h03
`define MAD_OFS_CAS2_LAT 8'h04
// Field masks and positions.
`define MAD_EC_WIDTH_MASK 7'h7f
`define MAD_EC_DOUBLE_BIT 7
`define MAD_BURST_MASK 8'h8f
`define MAD_LAT_MASK 8'h7f
`define MAD_MOD_FEAT_MASK 8'h7f
`define MAD_DEV_FEAT_MASK 8'h3f
`define MAD_ROLLUP_MAX 4'h3
`define MAD_ROLLUP_ADD 5'h0f
`define MAD_TENTHS_MAX 4'h9
// Reset value of the stored bytes; control register bit positions.
`define MAD_RST_BYTE 8'h00
`define MAD_CTRL_LOCK_BIT 0
`define MAD_CTRL_EC_SEP_BIT 1
`endif

// ### mad_attr_decoder.v
// How it works
// - Byte 14 bits 6:0 hold error-check width; zero undefined, 7f is 127.
// - Byte 14 bit 7 set only when second bank error-check width doubles.
// - Byte 14 width reported only when error checking uses separate components.
// - Byte 15 holds back-to-back column delay in clocks; zero undefined.
// - Byte 16 flags burst lengths 1,2,4,8 and page; bits 6:4 zero.
// - Byte 17 counts internal banks per component; zero is reserved.
// - Byte 18 bit n flags column latency n+1, bits 0 to 6.
// - Byte 19 bit n flags select latency n, bits 0 to 6.
// - Byte 20 bit n flags write latency n, bits 0 to 6.
// - Byte 21 flags module features on bits 0 to 6; bit 7 zero.
// - Buffered and registered control flags cover the whole control group.
// - Byte 22 flags precharge and write features bits 0 to 3; 7:6 zero.
// - Byte 22 bits 4,5 give lower, upper supply tolerance: 0=10%, 1=5%.
// - Byte 23 upper nibble whole ns, lower nibble 0 to 9 tenths.
// - Byte 23 upper nibble zero undefined; 1 to 3 read as 16 to 18.
module mad_attr_decoder #(
  parameter ADDR_W = 8
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_b_i,
  // Register port.
  input wire [ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Decoded configuration.
  output reg [6:0] ec_width_o,
  output reg ec_double_o,
  output reg ec_width_valid_o,
  output reg [7:0] col_delay_o,
  output reg col_delay_valid_o,
  output reg [4:0] burst_o,
  output reg [7:0] banks_o,
  output reg banks_valid_o,
  output reg [6:0] cas_lat_o,
  output reg [6:0] cs_lat_o,
  output reg [6:0] we_lat_o,
  output reg [6:0] mod_feat_o,
  output reg [3:0] dev_feat_o,
  output reg vcc_low_5pct_o,
  output reg vcc_high_5pct_o,
  output reg [4:0] cyc2_ns_o,
  output reg [3:0] cyc2_tenths_o,
  output reg cyc2_valid_o,
  output reg [2:0] cas2_lat_o,
  output reg cas2_valid_o
);
`include "mad_defines.vh"

  // Stored attribute bytes, indexed by offset minus the first offset.
  wire [7:0] byte_q [0:9];
  reg lock_q;
  reg ec_sep_q;
  wire [7:0] rel = addr_i[7:0] - `MAD_OFS_EC_WIDTH;
  wire in_map = (addr_i[7:0] >= `MAD_OFS_EC_WIDTH) && (addr_i[7:0] <= `MAD_OFS_CYCLE2);

  // Second-highest set bit of a latency mask, as a latency index plus one.
  function [3:0] second_high;
    input [6:0] m;
    integer k;
    reg seen;
    begin
      second_high = 4'h0;
      seen = 1'b0;
      for (k = 6; k >= 0; k = k - 1) begin
        if (m[k] && second_high == 4'h0) begin
          if (seen) begin
            second_high = k[3:0] + 4'h1;
          end
          seen = 1'b1;
        end
      end
    end
  endfunction

  // Bytes load from software until locked; lock keeps them stable once the controller has read them.
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_byte
      // Each byte owns its flip-flops, so every element has a single driver.
      reg [7:0] val_q;
      always @(posedge clk_i) begin
        if (!rst_b_i) begin
          val_q <= `MAD_RST_BYTE;
        end else if (wr_i && !lock_q && in_map && rel == g) begin
          val_q <= wdata_i;
        end
      end
      assign byte_q[g] = val_q;
    end
  endgenerate

  // Control register: lock and separate error-check flag.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      lock_q <= 1'b0;
      ec_sep_q <= 1'b0;
    end else if (wr_i && addr_i[7:0] == `MAD_OFS_CTRL) begin
      lock_q <= wdata_i[`MAD_CTRL_LOCK_BIT];
      ec_sep_q <= wdata_i[`MAD_CTRL_EC_SEP_BIT];
    end
  end

  // Combinational decode of the stored bytes.
  reg [7:0] b14, b16, b18, b19, b20, b21, b22, b23;
  reg [3:0] sh;
  reg [4:0] ns_d;
  always @* begin
    b14 = byte_q[0];
    b16 = byte_q[2] & `MAD_BURST_MASK;
    b18 = byte_q[4] & `MAD_LAT_MASK;
    b19 = byte_q[5] & `MAD_LAT_MASK;
    b20 = byte_q[6] & `MAD_LAT_MASK;
    b21 = byte_q[7] & `MAD_MOD_FEAT_MASK;
    b22 = byte_q[8] & `MAD_DEV_FEAT_MASK;
    b23 = byte_q[9];
    sh = second_high(b18[6:0]);
    if (b23[7:4] != 4'h0 && b23[7:4] <= `MAD_ROLLUP_MAX) begin
      ns_d = {1'b0, b23[7:4]} + `MAD_ROLLUP_ADD;
    end else begin
      ns_d = {1'b0, b23[7:4]};
    end
  end

  // Registered decoded outputs.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ec_width_o <= 7'h00;
      ec_double_o <= 1'b0;
      ec_width_valid_o <= 1'b0;
      col_delay_o <= 8'h00;
      col_delay_valid_o <= 1'b0;
      burst_o <= 5'h00;
      banks_o <= 8'h00;
      banks_valid_o <= 1'b0;
      cas_lat_o <= 7'h00;
      cs_lat_o <= 7'h00;
      we_lat_o <= 7'h00;
      mod_feat_o <= 7'h00;
      dev_feat_o <= 4'h0;
      vcc_low_5pct_o <= 1'b0;
      vcc_high_5pct_o <= 1'b0;
      cyc2_ns_o <= 5'h00;
      cyc2_tenths_o <= 4'h0;
      cyc2_valid_o <= 1'b0;
      cas2_lat_o <= 3'h0;
      cas2_valid_o <= 1'b0;
    end else begin
      ec_width_o <= ec_sep_q ? (b14[6:0] & `MAD_EC_WIDTH_MASK) : 7'h00;
      ec_width_valid_o <= ec_sep_q && (b14[6:0] != 7'h00);
      ec_double_o <= ec_sep_q && b14[`MAD_EC_DOUBLE_BIT];
      col_delay_o <= byte_q[1];
      col_delay_valid_o <= byte_q[1] != 8'h00;
      // Burst flags, page in the top bit.
      burst_o <= {b16[7], b16[3:0]};
      banks_o <= byte_q[3];
      banks_valid_o <= byte_q[3] != 8'h00;
      // Latency flags, undefined bit 7 dropped.
      cas_lat_o <= b18[6:0];
      cs_lat_o <= b19[6:0];
      we_lat_o <= b20[6:0];
      mod_feat_o <= b21[6:0];
      dev_feat_o <= b22[3:0];
      vcc_low_5pct_o <= b22[4];
      vcc_high_5pct_o <= b22[5];
      // Cycle time; tenths above nine make it undefined.
      cyc2_ns_o <= ns_d;
      cyc2_tenths_o <= b23[3:0];
      cyc2_valid_o <= (b23[7:4] != 4'h0) && (b23[3:0] <= `MAD_TENTHS_MAX);
      // Latency that the cycle time belongs to.
      cas2_lat_o <= sh[2:0];
      cas2_valid_o <= sh != 4'h0;
    end
  end

  // Read port: data one cycle after the strobe, zero elsewhere.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (in_map) begin
        rdata_o <= byte_q[rel[3:0]];
      end else begin
        case (addr_i[7:0])
          `MAD_OFS_CTRL: rdata_o <= {6'h00, ec_sep_q, lock_q};
          `MAD_OFS_STATUS: rdata_o <= {4'h0, cas2_valid_o, cyc2_valid_o, banks_valid_o, ec_width_valid_o};
          `MAD_OFS_CYC2_NS: rdata_o <= {3'h0, cyc2_ns_o};
          `MAD_OFS_CYC2_TENTHS: rdata_o <= {4'h0, cyc2_tenths_o};
          `MAD_OFS_CAS2_LAT: rdata_o <= {5'h00, cas2_lat_o};
          default: rdata_o <= 8'h00;
        endcase
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

// ### mad_reader.sv
// Reader model: picks the latency that the cycle-time byte belongs to.
module mad_reader (
  input wire logic [6:0] lat_i,
  output logic [2:0] sec_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] top;
  always_comb begin
    top = 3'h0;
    sec_o = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (lat_i[i]) begin
        sec_o = top;
        top = 3'(i + 1);
      end
    end
  end
endmodule

// ### mad_attr_decoder_properties.sv
// Relations between the decoded outputs and the register port.
module mad_attr_checker (
  input wire clk_i, rst_b_i, wr_i, rd_i, ec_width_valid_o, col_delay_valid_o, banks_valid_o, cyc2_valid_o, cas2_valid_o,
  input wire [7:0] addr_i, rdata_o, col_delay_o, banks_o,
  input wire [6:0] ec_width_o, cas_lat_o,
  input wire [4:0] cyc2_ns_o,
  input wire [3:0] cyc2_tenths_o,
  input wire [2:0] cas2_lat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_unmapped; rd_i && addr_i >= 8'h18 |=> rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Two quiet cycles leave no decode update in flight.
  property p_cas_hold; !wr_i ##1 !wr_i |=> $stable(cas_lat_o); endproperty
  a_cas_hold: assert property (p_cas_hold) else $error("latency flags moved without write");
  property p_cyc_hold; !wr_i ##1 !wr_i |=> $stable(cyc2_ns_o); endproperty
  a_cyc_hold: assert property (p_cyc_hold) else $error("cycle time moved without write");
  property p_cas2; cas2_valid_o |-> cas_lat_o[cas2_lat_o - 3'h1] && (cas_lat_o >> cas2_lat_o) != 7'h0; endproperty
  a_cas2: assert property (p_cas2) else $error("second latency wrong");
  property p_cyc2; cyc2_valid_o |-> cyc2_ns_o >= 5'h4 && cyc2_tenths_o <= 4'h9; endproperty
  a_cyc2: assert property (p_cyc2) else $error("cycle time out of range");
  property p_cyc_undef; cyc2_ns_o == 5'h0 |-> !cyc2_valid_o; endproperty
  a_cyc_undef: assert property (p_cyc_undef) else $error("zero cycle time valid");
  property p_banks; banks_valid_o == (banks_o != 8'h00); endproperty
  a_banks: assert property (p_banks) else $error("bank valid wrong");
  property p_col; col_delay_valid_o == (col_delay_o != 8'h00); endproperty
  a_col: assert property (p_col) else $error("column delay valid wrong");
  property p_ec; ec_width_valid_o |-> ec_width_o != 7'h0; endproperty
  a_ec: assert property (p_ec) else $error("zero width valid");
  c_cas2: cover property (cas2_valid_o);
  c_cyc2: cover property (cyc2_valid_o);
  c_rd: cover property (rd_i ##1 rdata_o != 8'h00);
endmodule
bind mad_attr_decoder mad_attr_checker chk_u (.clk_i, .rst_b_i, .wr_i, .rd_i, .ec_width_valid_o, .col_delay_valid_o,
  .banks_valid_o, .cyc2_valid_o, .cas2_valid_o, .addr_i, .rdata_o, .col_delay_o, .banks_o, .ec_width_o, .cas_lat_o,
  .cyc2_ns_o, .cyc2_tenths_o, .cas2_lat_o);

// ### test_mad_attr_decoder.sv
module test_mad_attr_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, banks_o, col_delay_o;
  logic [6:0] ec_width_o, cas_lat_o, cs_lat_o, we_lat_o, mod_feat_o;
  logic [4:0] burst_o, cyc2_ns_o;
  logic [3:0] dev_feat_o, cyc2_tenths_o;
  logic [2:0] cas2_lat_o, sec;
  logic ec_double_o, ec_width_valid_o, col_delay_valid_o, banks_valid_o;
  logic vcc_low_5pct_o, vcc_high_5pct_o, cyc2_valid_o, cas2_valid_o;
  int failures = 0, compares = 0;
  mad_attr_decoder dut_u (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ec_width_o, .ec_double_o,
    .ec_width_valid_o, .col_delay_o, .col_delay_valid_o, .burst_o, .banks_o, .banks_valid_o, .cas_lat_o, .cs_lat_o,
    .we_lat_o, .mod_feat_o, .dev_feat_o, .vcc_low_5pct_o, .vcc_high_5pct_o, .cyc2_ns_o, .cyc2_tenths_o,
    .cyc2_valid_o, .cas2_lat_o, .cas2_valid_o);
  mad_reader rdr_u (.lat_i(7'h0e), .sec_o(sec));
  always #20 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1;
    chk("rdata", e, rdata_o);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // The whole sequence needs a few microseconds.
  initial begin
    #50000;
    failures++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1;
    rd(8'h12, 8'h00);
    wr(8'h0e, 8'hff);
    settle;
    chk("ec_valid", 8'h00, {7'h0, ec_width_valid_o});
    chk("ec_width", 8'h00, {1'b0, ec_width_o});
    $display("test reset and gating done");
    wr(8'h00, 8'h02);
    wr(8'h10, 8'hff);
    wr(8'h12, 8'h0e);
    wr(8'h16, 8'hff);
    wr(8'h17, 8'h25);
    settle;
    chk("ec_width", 8'h7f, {1'b0, ec_width_o});
    chk("ec_double", 8'h01, {7'h0, ec_double_o});
    chk("burst", 8'h1f, {3'h0, burst_o});
    chk("cas2", {5'h0, sec}, {5'h0, cas2_lat_o});
    chk("dev_feat", 8'h3f, {2'h0, vcc_high_5pct_o, vcc_low_5pct_o, dev_feat_o});
    chk("cyc2_ns", 8'h11, {3'h0, cyc2_ns_o});
    chk("cyc2_tenths", 8'h05, {4'h0, cyc2_tenths_o});
    chk("banks_valid", 8'h00, {7'h0, banks_valid_o});
    chk("col_valid", 8'h00, {7'h0, col_delay_valid_o});
    $display("test decode done");
    wr(8'h0f, 8'h04);
    wr(8'h11, 8'h04);
    wr(8'h13, 8'hff);
    wr(8'h14, 8'h81);
    wr(8'h15, 8'hff);
    settle;
    chk("col_delay", 8'h04, col_delay_o);
    chk("col_valid", 8'h01, {7'h0, col_delay_valid_o});
    chk("banks", 8'h04, banks_o);
    chk("cas_lat", 8'h0e, {1'b0, cas_lat_o});
    chk("cs_lat", 8'h7f, {1'b0, cs_lat_o});
    chk("we_lat", 8'h01, {1'b0, we_lat_o});
    chk("mod_feat", 8'h7f, {1'b0, mod_feat_o});
    chk("cas2_valid", 8'h01, {7'h0, cas2_valid_o});
    rd(8'h01, 8'h0f);
    rd(8'h02, 8'h11);
    rd(8'h03, 8'h05);
    rd(8'h04, 8'h03);
    wr(8'h17, 8'h3a);
    settle;
    chk("cyc2_ns", 8'h12, {3'h0, cyc2_ns_o});
    chk("cyc2_valid", 8'h00, {7'h0, cyc2_valid_o});
    $display("test features and status done");
    rd(8'h12, 8'h0e);
    rd(8'h30, 8'h00);
    wr(8'h00, 8'h03);
    wr(8'h12, 8'h7f);
    rd(8'h12, 8'h0e);
    $display("test readback and lock done");
    stop_test;
  end
endmodule
